// >>> sfr_consts.svh
// What this block does
// (R1) Hold reset until supply passes power-on level, then load defaults and init.
// (R2) After init, pull interrupt low, set power-on flag and serial power-on flag.
// (R3) Failed self-check sets its error flag with power-on; host should then soft reset.
// (R4) Run bit at one enables wetting current and switch monitoring.
// (R5) While running, config writes are refused except run, checksum, reset, clean-current.
// (R6) Host clears run bit to stop, reconfigures, then sets run again.
// (R7) Checksum stays usable while the run bit is one.
// (R8) Logic supply loss stops serial traffic but keeps all registers; here writes still land, with an error response.
// (R9) Main supply below power-on level clears everything; rising again reinitialises.
// (R10) Reset pin high holds device in reset with registers cleared; low is normal.
// (R11) Reset pin low again reinitialises and then flags power-on with interrupt.
// (R12) Host holds reset pin high at least 2 us for it to take effect.
// (R13) With an interrupt pending, the reset sequence may take up to 1 ms.
// (R14) Writing one to reset bit reinitialises and then flags power-on with interrupt.
// (R15) Under-voltage entry turns off all currents and halts monitoring.
// (R16) Fault entry sets event flag, level flag, interrupt and serial other flag.
// (R17) Chip select rise clears interrupt status only if it was read that frame.
// (R18) During a supply fault serial access and register contents remain intact.
// (R19) A persisting fault raises no further interrupt once cleared.
// (R20) Under-voltage exit sets event flag, clears level flag, asserts interrupt.
// (R21) Over-voltage enters above rise level, leaves below it minus hysteresis.
// (R22) After a fault clears, polling restarts from the first channel regardless.
// (R23) First polling cycle after recovery raises a switch change event.
// (R24) Interrupt pin falls within 20 us of a supply fault detection.
// (R25) Supply comparisons arrive as digital levels, synchronised before use.
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// Register byte offsets
`define SFR_OFS_CONFIG 8'h00
`define SFR_OFS_CLEAN_CFG 8'h04
`define SFR_OFS_INT_STAT 8'h08
`define SFR_OFS_MISC_STAT 8'h0C
`define SFR_OFS_CHECKSUM 8'h10
`define SFR_OFS_LINK_STAT 8'h14

// Config register fields
`define SFR_CFG_RUN 0
`define SFR_CFG_CRC_START 1
`define SFR_CFG_RESET 2
`define SFR_CFG_LOCK_LO 8
`define SFR_CFG_LOCK_HI 23

// Interrupt status fields
`define SFR_INT_POR 0
`define SFR_INT_SELFCHECK 1
`define SFR_INT_UV 2
`define SFR_INT_OV 3
`define SFR_INT_SWITCH 4
`define SFR_INT_W 5

// Misc status fields
`define SFR_MISC_UV 0
`define SFR_MISC_OV 1

// Reset values
`define SFR_RST_CONFIG 32'h0000_0000
`define SFR_RST_CLEAN_CFG 32'h0000_0000

// Timing
`define SFR_CLK_MHZ 50
`define SFR_RESET_MIN_NS 2000
`define SFR_RESET_MIN_CYC ((`SFR_RESET_MIN_NS * `SFR_CLK_MHZ + 999) / 1000)
`define SFR_INIT_NS 10000
`define SFR_INIT_CYC ((`SFR_INIT_NS * `SFR_CLK_MHZ) / 1000)
`define SFR_INIT_PEND_NS 1000000
`define SFR_INIT_PEND_CYC ((`SFR_INIT_PEND_NS * `SFR_CLK_MHZ) / 1000)
`define SFR_REACT_MAX_NS 20000

`endif

// >>> sfr_pkg.sv
package sfr_pkg;
  // Device life cycle
  typedef enum logic [1:0] {
    SFR_HOLD,
    SFR_INIT,
    SFR_READY
  } sfr_state_e;

  // Bus response codes
  typedef logic [1:0] sfr_resp_t;
  localparam sfr_resp_t SFR_OKAY = 2'h0;
  localparam sfr_resp_t SFR_SLVERR = 2'h2;
endpackage

// >>> sfr_top.sv
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`include "sfr_consts.svh"

module sfr_top #(
  parameter int unsigned INIT_PEND_CYC = `SFR_INIT_PEND_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Supply comparators and pins, asynchronous
  input wire logic supply_por_ok,
  input wire logic logic_supply_ok,
  input wire logic undervolt_low,
  input wire logic overvolt_high,
  input wire logic reset_pin,
  input wire logic chip_select_n,
  input wire logic serial_clk,
  // Internal status from the scanner and trim checker
  input wire logic selfcheck_pass,
  input wire logic poll_cycle_done,
  // Device outputs
  output logic int_n,
  output logic wetting_en,
  output logic monitor_en,
  output logic poll_restart,
  output logic serial_active,
  output logic por_serial_flag,
  output logic other_irq_serial_flag
);

  // ==========================================================
  // Synchronisers
  // ==========================================================
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic s_por_ok, s_vdd_ok, s_uv, s_ov, s_rst_pin, s_cs_n, s_sclk;

  // Two flops on every outside level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {supply_por_ok, logic_supply_ok, undervolt_low, overvolt_high,
                 reset_pin, chip_select_n, serial_clk}; // R25
      sync_b <= sync_a;
    end
  end

  assign {s_por_ok, s_vdd_ok, s_uv, s_ov, s_rst_pin, s_cs_n, s_sclk} = sync_b;

  // Edge history of the link pins
  logic cs_n_d, sclk_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_n_d <= s_cs_n;
      sclk_d <= s_sclk;
    end
  end

  logic cs_rise, cs_low, sclk_rise;
  assign cs_low = !s_cs_n && s_vdd_ok; // R8
  assign cs_rise = s_cs_n && !cs_n_d;
  assign sclk_rise = s_sclk && !sclk_d && cs_low;

  // ==========================================================
  // Reset pin filter
  // ==========================================================
  logic [7:0] rst_cnt;
  logic pin_reset;

  // Pin must stay high a minimum time before it counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt <= '0;
      pin_reset <= 1'b0;
    end else if (!s_rst_pin) begin
      rst_cnt <= '0;
      pin_reset <= 1'b0;
    end else if (rst_cnt >= 8'(`SFR_RESET_MIN_CYC - 1)) begin
      pin_reset <= 1'b1; // R12
    end else begin
      rst_cnt <= rst_cnt + 8'h01;
    end
  end

  // ==========================================================
  // Life cycle
  // ==========================================================
  sfr_pkg::sfr_state_e state;
  logic [31:0] config_reg;
  logic [`SFR_INT_W-1:0] int_stat;
  logic [19:0] init_cnt;
  logic init_done;
  logic soft_reset;
  logic hold_cond;

  assign hold_cond = !s_por_ok || pin_reset; // R9 R10
  assign soft_reset = config_reg[`SFR_CFG_RESET];

  // Hold, then count the init time, longer after a soft reset with an interrupt pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= sfr_pkg::SFR_HOLD;
      init_cnt <= '0;
      init_done <= 1'b0;
    end else begin
      init_done <= 1'b0;
      unique case (state)
        sfr_pkg::SFR_HOLD: begin
          init_cnt <= '0;
          if (!hold_cond) begin
            state <= sfr_pkg::SFR_INIT; // R1 R11
          end
        end
        sfr_pkg::SFR_INIT: begin
          init_cnt <= init_cnt + 20'h0_0001;
          if (hold_cond) begin
            state <= sfr_pkg::SFR_HOLD;
          end else if (init_cnt == 20'(`SFR_INIT_CYC - 1)) begin // Wrapped start must count through
            state <= sfr_pkg::SFR_READY;
            init_done <= 1'b1;
          end
        end
        sfr_pkg::SFR_READY: begin
          init_cnt <= '0;
          if (hold_cond) begin
            state <= sfr_pkg::SFR_HOLD;
          end else if (soft_reset) begin
            state <= sfr_pkg::SFR_INIT; // R14
            init_cnt <= (|int_stat) ? 20'(`SFR_INIT_CYC) - 20'(INIT_PEND_CYC) : '0; // R13
          end
        end
      endcase
    end
  end

  logic dev_clear;
  assign dev_clear = !aresetn || state != sfr_pkg::SFR_READY;

  // ==========================================================
  // Supply fault tracking
  // ==========================================================
  logic uv_level, ov_level, fault_exit, ssc_armed;
  logic [1:0] fault_rise, fault_fall;

  assign fault_rise = {s_ov && !ov_level, s_uv && !uv_level}; // R19
  assign fault_fall = {!s_ov && ov_level, !s_uv && uv_level};
  assign fault_exit = |fault_fall && !(s_uv || s_ov);

  // Level flags follow the comparators
  always_ff @(posedge aclk) begin
    if (dev_clear) begin
      uv_level <= 1'b0;
      ov_level <= 1'b0;
    end else begin
      uv_level <= s_uv; // R15 R20
      ov_level <= s_ov; // R21
    end
  end

  // Recovery restarts polling and arms the first-cycle change event
  always_ff @(posedge aclk) begin
    if (dev_clear) begin
      poll_restart <= 1'b0;
      ssc_armed <= 1'b0;
    end else begin
      poll_restart <= fault_exit; // R22
      if (fault_exit) begin
        ssc_armed <= 1'b1;
      end else if (poll_cycle_done && monitor_en) begin
        ssc_armed <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register file
  // ==========================================================
  logic [31:0] clean_cfg;
  logic [31:0] checksum;
  logic [15:0] link_bits;
  logic int_read_seen;
  logic wr_go, rd_go;
  logic [7:0] aw_addr_q, ar_addr;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_have, w_have;

  // Byte lane merge
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Word fold checksum of the settings
  function automatic logic [31:0] fold(input logic [31:0] a, input logic [31:0] b);
    return {a[30:0], a[31]} ^ b;
  endfunction

  logic [31:0] cfg_new;
  assign cfg_new = merge(config_reg, w_data_q, w_strb_q);

  // Config: lockable field frozen while running
  always_ff @(posedge aclk) begin
    if (dev_clear) begin
      config_reg <= `SFR_RST_CONFIG;
    end else begin
      config_reg[`SFR_CFG_CRC_START] <= 1'b0;
      if (wr_go && aw_addr_q == `SFR_OFS_CONFIG) begin
        config_reg[`SFR_CFG_RUN] <= cfg_new[`SFR_CFG_RUN]; // R4 R6
        config_reg[`SFR_CFG_CRC_START] <= cfg_new[`SFR_CFG_CRC_START]; // R7
        config_reg[`SFR_CFG_RESET] <= cfg_new[`SFR_CFG_RESET]; // R14
        if (!config_reg[`SFR_CFG_RUN]) begin
          config_reg[`SFR_CFG_LOCK_HI:`SFR_CFG_LOCK_LO] <=
            cfg_new[`SFR_CFG_LOCK_HI:`SFR_CFG_LOCK_LO]; // R5
        end
      end
    end
  end

  // Clean-current config is always writable
  always_ff @(posedge aclk) begin
    if (dev_clear) begin
      clean_cfg <= `SFR_RST_CLEAN_CFG;
    end else if (wr_go && aw_addr_q == `SFR_OFS_CLEAN_CFG) begin
      clean_cfg <= merge(clean_cfg, w_data_q, w_strb_q); // R5
    end
  end

  // Checksum runs on request in any run state
  always_ff @(posedge aclk) begin
    if (dev_clear) begin
      checksum <= '0;
    end else if (config_reg[`SFR_CFG_CRC_START]) begin
      checksum <= fold(fold(32'hFFFF_FFFF, config_reg & 32'h00FF_FF01), clean_cfg); // R7
    end
  end

  // Interrupt status: hardware sets win over the frame-end clear
  logic [`SFR_INT_W-1:0] int_set;
  always_comb begin
    int_set = '0;
    int_set[`SFR_INT_POR] = init_done; // R2 R11 R14
    int_set[`SFR_INT_SELFCHECK] = init_done && !selfcheck_pass; // R3
    int_set[`SFR_INT_UV] = fault_rise[0] || fault_fall[0]; // R16 R20
    int_set[`SFR_INT_OV] = fault_rise[1] || fault_fall[1]; // R16 R21
    int_set[`SFR_INT_SWITCH] = ssc_armed && poll_cycle_done && monitor_en; // R23
  end

  always_ff @(posedge aclk) begin
    if (dev_clear) begin
      int_stat <= '0;
    end else if (cs_rise && int_read_seen) begin
      int_stat <= int_set; // R17
    end else begin
      int_stat <= int_stat | int_set;
    end
  end

  // Remember a status read within the current frame
  always_ff @(posedge aclk) begin
    if (dev_clear || cs_rise) begin
      int_read_seen <= 1'b0;
    end else if (rd_go && ar_addr == `SFR_OFS_INT_STAT && cs_low) begin
      int_read_seen <= 1'b1;
    end
  end

  // Link clock edges counted per frame
  always_ff @(posedge aclk) begin
    if (dev_clear || cs_rise) begin
      link_bits <= '0;
    end else if (sclk_rise) begin
      link_bits <= link_bits + 16'h0001;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  // ==========================================================
  // Serial access remains during faults; without logic supply reads fail, writes still land but answer with an error
  logic bus_ok;
  assign bus_ok = s_vdd_ok; // R8 R18

  // Capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sfr_pkg::SFR_OKAY;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready <= !w_have && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (bus_ok && (aw_addr_q == `SFR_OFS_CONFIG ||
                        aw_addr_q == `SFR_OFS_CLEAN_CFG)) ? sfr_pkg::SFR_OKAY
                                                           : sfr_pkg::SFR_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_go = aw_have && w_have && !s_axi_bvalid;

  // Read path, data one cycle after the address is taken
  assign rd_go = s_axi_arvalid && s_axi_arready && bus_ok;
  assign ar_addr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sfr_pkg::SFR_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= sfr_pkg::SFR_OKAY;
        s_axi_rdata <= '0;
        if (!bus_ok) begin
          s_axi_rresp <= sfr_pkg::SFR_SLVERR;
        end else begin
          unique case (s_axi_araddr)
            `SFR_OFS_CONFIG: s_axi_rdata <= config_reg;
            `SFR_OFS_CLEAN_CFG: s_axi_rdata <= clean_cfg;
            `SFR_OFS_INT_STAT: s_axi_rdata <= {27'h000_0000, int_stat};
            `SFR_OFS_MISC_STAT: s_axi_rdata <= {30'h0000_0000, ov_level, uv_level};
            `SFR_OFS_CHECKSUM: s_axi_rdata <= checksum;
            `SFR_OFS_LINK_STAT: s_axi_rdata <= {14'h0000, cs_low, 1'b0, link_bits};
            default: s_axi_rresp <= sfr_pkg::SFR_SLVERR;
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Device outputs
  // ==========================================================
  // Currents and monitoring need run bit, ready state and no fault
  always_ff @(posedge aclk) begin
    if (dev_clear) begin
      wetting_en <= 1'b0;
      monitor_en <= 1'b0;
      int_n <= 1'b1;
      serial_active <= 1'b0;
      por_serial_flag <= 1'b0;
      other_irq_serial_flag <= 1'b0;
    end else begin
      wetting_en <= config_reg[`SFR_CFG_RUN] && !s_uv && !s_ov; // R4 R15 R21
      monitor_en <= config_reg[`SFR_CFG_RUN] && !s_uv && !s_ov; // R4 R15 R21
      int_n <= !(|(int_stat | int_set)); // R24
      serial_active <= s_vdd_ok; // R8
      por_serial_flag <= int_stat[`SFR_INT_POR] || int_set[`SFR_INT_POR]; // R2
      other_irq_serial_flag <= |(int_stat[`SFR_INT_OV:`SFR_INT_UV]); // R16
    end
  end

endmodule

// >>> sfr_top_assertions.sv
`timescale 1ns/10ps
// ==========
// Checker
module sfr_top_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Supply and pin inputs
  input wire logic supply_por_ok,
  input wire logic logic_supply_ok,
  input wire logic undervolt_low,
  input wire logic overvolt_high,
  input wire logic reset_pin,
  // Device outputs
  input wire logic int_n,
  input wire logic monitor_en,
  input wire logic poll_restart,
  input wire logic serial_active,
  input wire logic por_serial_flag,
  input wire logic other_irq_serial_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [6:0] pin_cnt;
  // Cycles of a held reset pin, saturating past the filter
  always_ff @(posedge aclk) begin
    if (!aresetn || !reset_pin) pin_cnt <= 7'h00;
    else if (pin_cnt != 7'h6E) pin_cnt <= pin_cnt + 7'h01;
  end
  // Fault seen while monitoring, and the interrupt answer
  sequence fault_up;
    monitor_en && (undervolt_low || overvolt_high);
  endsequence
  sequence int_low;
    !int_n;
  endsequence
  AST_REACT: assert property (fault_up |-> ##[0:1000] int_low)
    else $error("interrupt late after supply fault");
  AST_UV_STOP: assert property ($rose(undervolt_low) |-> ##[1:8] !monitor_en)
    else $error("monitoring kept on in under-voltage");
  AST_OV_STOP: assert property ($rose(overvolt_high) |-> ##[1:8] !monitor_en)
    else $error("monitoring kept on in over-voltage");
  AST_OI: assert property (other_irq_serial_flag ##1 other_irq_serial_flag |-> int_low)
    else $error("fault flag without interrupt");
  AST_POR: assert property (por_serial_flag [*2] |-> int_low)
    else $error("power-on flag without interrupt");
  AST_RESTART: assert property (poll_restart |=> !poll_restart)
    else $error("restart pulse too long");
  AST_PIN_RST: assert property (pin_cnt == 7'h6E |-> int_n && !monitor_en && !por_serial_flag)
    else $error("reset pin did not clear device");
  AST_POR_LOST: assert property (!supply_por_ok [*8] |-> int_n && !monitor_en)
    else $error("device alive without main supply");
  AST_VDD_OFF: assert property (!logic_supply_ok [*5] |-> !serial_active)
    else $error("serial active without logic supply");
endmodule

// >>> sfr_link_host.sv
`timescale 1ns/10ps
// ==========
// Link host model
module sfr_link_host (
  // Frame request
  input wire logic open_frame,
  input wire logic [7:0] n_clk,
  // Link pins
  output logic chip_select_n,
  output logic serial_clk
);
  // Link clock of 160 ns runs only inside frames
  initial begin
    chip_select_n = 1'h1;
    serial_clk = 1'h0;
    forever begin
      @(posedge open_frame);
      #37 chip_select_n = 1'h0;
      #100;
      repeat (n_clk) begin
        serial_clk = 1'h1;
        #80 serial_clk = 1'h0;
        #80;
      end
      @(negedge open_frame);
      #100 chip_select_n = 1'h1;
    end
  end
endmodule

// >>> test_supply_fault_and_reset_control.sv
`timescale 1ns/10ps
`include "sfr_consts.svh"
module test_supply_fault_and_reset_control;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v, ev;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic supply_por_ok, logic_supply_ok, undervolt_low, overvolt_high, reset_pin;
  logic chip_select_n, serial_clk, selfcheck_pass, poll_cycle_done, open_frame;
  logic int_n, wetting_en, monitor_en, poll_restart, serial_active;
  logic por_serial_flag, other_irq_serial_flag;
  int num_errors, tests_run, cyc, n_restart, f;
  localparam logic [1:0] OK = sfr_pkg::SFR_OKAY;
  localparam logic [1:0] ERR = sfr_pkg::SFR_SLVERR;
  // Device, soft reset with pending interrupt shortened
  sfr_top #(.INIT_PEND_CYC(600)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_por_ok, .logic_supply_ok,
    .undervolt_low, .overvolt_high, .reset_pin, .chip_select_n, .serial_clk, .selfcheck_pass,
    .poll_cycle_done, .int_n, .wetting_en, .monitor_en, .poll_restart, .serial_active,
    .por_serial_flag, .other_irq_serial_flag);
  // Link host
  sfr_link_host host (.open_frame, .n_clk(8'h05), .chip_select_n, .serial_clk);
  // Clock
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  // Timeout and restart pulse counter
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (poll_restart === 1'h1) n_restart <= n_restart + 1;
    if (cyc == 40000) begin
      num_errors++;
      summarize();
    end
  end
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready === 1'h1) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    s_axi_bready <= 1'h0;
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    s_axi_rready <= 1'h0;
    chk("rresp", er, s_axi_rresp);
    if (er == OK) chk("rdata", e, s_axi_rdata);
  endtask
  task automatic wait_int(input logic lvl, input int n);
    for (int i = 0; i < n && int_n !== lvl; i++) @(posedge aclk);
    chk("int_n", lvl, int_n);
  endtask
  task automatic frame(input logic [31:0] e);
    @(posedge aclk);
    open_frame <= 1'h1;
    repeat (70) @(posedge aclk);
    rd(`SFR_OFS_LINK_STAT, 32'h0002_0005, OK);
    rd(`SFR_OFS_INT_STAT, e, OK);
    open_frame <= 1'h0;
    repeat (20) @(posedge aclk);
  endtask
  task automatic set_fault(input int k, input logic v);
    if (k == 0) undervolt_low <= v;
    else overvolt_high <= v;
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {undervolt_low, overvolt_high, reset_pin, poll_cycle_done, open_frame} = '0;
    {cyc, n_restart, num_errors, tests_run} = '0;
    s_axi_wstrb = 4'hF;
    {supply_por_ok, logic_supply_ok, selfcheck_pass} = 3'h7;
    repeat (20) @(posedge aclk);
    chk("int_n in reset", 1'h1, int_n);
    aresetn <= 1'h1;
    wait_int(1'h0, 1000);
    rd(`SFR_OFS_INT_STAT, 32'h0000_0001, OK);
    chk("por flag", 1'h1, por_serial_flag);
    frame(32'h0000_0001);
    wait_int(1'h1, 20);
    rd(`SFR_OFS_INT_STAT, 32'h0000_0000, OK);
    $display("test done: power-on");
    wr(`SFR_OFS_CONFIG, 32'h0000_1201, OK);
    wr(`SFR_OFS_CONFIG, 32'h0000_3401, OK);
    rd(`SFR_OFS_CONFIG, 32'h0000_1201, OK);
    chk("monitor_en", 1'h1, monitor_en);
    chk("wetting_en", 1'h1, wetting_en);
    wr(`SFR_OFS_CLEAN_CFG, 32'h0000_00A5, OK);
    rd(`SFR_OFS_CLEAN_CFG, 32'h0000_00A5, OK);
    wr(`SFR_OFS_CONFIG, 32'h0000_1203, OK);
    rd(`SFR_OFS_CHECKSUM, 32'hFFFF_DB58, OK);
    wr(`SFR_OFS_INT_STAT, 32'h0000_001F, ERR);
    rd(8'h3C, 32'h0000_0000, ERR);
    $display("test done: run lock");
    for (f = 0; f < 2; f++) begin
      ev = 32'h0000_0004 << f;
      set_fault(f, 1'h1);
      wait_int(1'h0, 1000);
      chk("monitor_en", 1'h0, monitor_en);
      rd(`SFR_OFS_INT_STAT, ev, OK);
      chk("oi flag", 1'h1, other_irq_serial_flag);
      rd(`SFR_OFS_MISC_STAT, 32'h0000_0001 << f, OK);
      rd(`SFR_OFS_CLEAN_CFG, 32'h0000_00A5, OK);
      chk("int_n", 1'h0, int_n);
      frame(ev);
      repeat (50) @(posedge aclk);
      chk("int_n", 1'h1, int_n);
      set_fault(f, 1'h0);
      wait_int(1'h0, 1000);
      rd(`SFR_OFS_MISC_STAT, 32'h0000_0000, OK);
      chk("restarts", f + 1, n_restart);
      chk("monitor_en", 1'h1, monitor_en);
      @(posedge aclk);
      poll_cycle_done <= 1'h1;
      @(posedge aclk);
      poll_cycle_done <= 1'h0;
      repeat (4) @(posedge aclk);
      rd(`SFR_OFS_INT_STAT, ev | 32'h0000_0010, OK);
      frame(ev | 32'h0000_0010);
      $display("test done: supply fault %0d", f);
    end
    logic_supply_ok <= 1'h0;
    repeat (10) @(posedge aclk);
    chk("serial_active", 1'h0, serial_active);
    rd(`SFR_OFS_CLEAN_CFG, 32'h0000_0000, ERR);
    logic_supply_ok <= 1'h1;
    repeat (10) @(posedge aclk);
    rd(`SFR_OFS_CLEAN_CFG, 32'h0000_00A5, OK);
    $display("test done: logic supply");
    wr(`SFR_OFS_CONFIG, 32'h0000_1205, OK);
    wait_int(1'h0, 1000);
    rd(`SFR_OFS_INT_STAT, 32'h0000_0001, OK);
    rd(`SFR_OFS_CLEAN_CFG, 32'h0000_0000, OK);
    rd(`SFR_OFS_CONFIG, 32'h0000_0000, OK);
    wr(`SFR_OFS_CONFIG, 32'h0000_0004, OK);
    repeat (550) @(posedge aclk);
    chk("int_n pending", 1'h1, int_n);
    wait_int(1'h0, 300);
    $display("test done: soft reset");
    selfcheck_pass <= 1'h0;
    reset_pin <= 1'h1;
    repeat (110) @(posedge aclk);
    chk("int_n pin reset", 1'h1, int_n);
    reset_pin <= 1'h0;
    wait_int(1'h0, 1000);
    rd(`SFR_OFS_INT_STAT, 32'h0000_0003, OK);
    selfcheck_pass <= 1'h1;
    $display("test done: reset pin");
    wr(`SFR_OFS_CLEAN_CFG, 32'h0000_005A, OK);
    supply_por_ok <= 1'h0;
    repeat (10) @(posedge aclk);
    chk("int_n supply off", 1'h1, int_n);
    supply_por_ok <= 1'h1;
    wait_int(1'h0, 1000);
    rd(`SFR_OFS_CLEAN_CFG, 32'h0000_0000, OK);
    rd(`SFR_OFS_INT_STAT, 32'h0000_0001, OK);
    $display("test done: supply loss");
    summarize();
  end
endmodule
bind sfr_top sfr_top_chk chk_i (.aclk, .aresetn, .supply_por_ok, .logic_supply_ok,
  .undervolt_low, .overvolt_high, .reset_pin, .int_n, .monitor_en, .poll_restart,
  .serial_active, .por_serial_flag, .other_irq_serial_flag);
